// ---- design/lecr_regs.sv ----
module lecr_regs #(
  parameter int STEP_CYC = lecr_pkg::LECR_ADAPT_STEP_CYC // cycles per adaptive search step
) (
  input wire logic i_clk, // 10 MHz clock
  input wire logic i_reset, // async reset, high
  input wire lecr_pkg::lecr_avm_req_s i_avm, // avalon request
  output logic [31:0] o_readdata, // avalon read data
  output logic o_waitrequest, // avalon wait
  input wire logic i_mode_strap, // long cable strap pin
  input wire lecr_pkg::lecr_frame_s i_frame, // received frame marker bits
  input wire logic i_eq_good, // equalizer quality ok at level
  output logic [5:0] o_eq_level, // applied equalizer level
  output logic o_pattern_internal_clock_select, // pattern gen clock choice
  output logic o_audio_div_override, // audio divider override
  output logic [2:0] o_audio_div, // audio divider value
  output logic o_lock, // link lock
  output logic o_long_cable_mode, // effective long cable mode
  output logic o_irq // level interrupt
);
  import lecr_pkg::*;

  // the step counter is eight bits wide, so longer steps cannot be counted
  if (STEP_CYC < 1 || STEP_CYC > 256) begin : g_step_check
    $error("step cycle count out of range");
  end

  logic [7:0] eq_ctrl, pg_clk, aud_div, err_cnt, eq_byp, eq_floor, irq_stat, irq_en;
  logic [3:0] err_count;
  logic strap_s1, strap_s2;
  lecr_frame_s frame_s1, frame_s2;
  logic good_s1, good_s2;
  logic [7:0] step_cnt;
  lecr_eq_e eq_state;
  logic [5:0] eq_adapt;
  logic ack;
  logic [7:0] rd_byte;

  wire logic acc = (i_avm.read | i_avm.write) & ~ack;
  // a write lands only at the edge that also sees waitrequest low
  wire logic wr = i_avm.write & ack;
  wire logic [7:0] wd = i_avm.writedata[7:0];
  // (R16) reserved bits dropped
  wire logic [7:0] wd_ctrl = wd & LECR_MSK_EQ_CTRL;
  wire logic hit_ctrl = wr & (i_avm.address == LECR_OFS_EQ_CTRL);
  wire logic hit_pg = wr & (i_avm.address == LECR_OFS_PG_CLK);
  wire logic hit_aud = wr & (i_avm.address == LECR_OFS_AUD_DIV);
  wire logic hit_err = wr & (i_avm.address == LECR_OFS_ERR_CNT);
  wire logic hit_byp = wr & (i_avm.address == LECR_OFS_EQ_BYP);
  wire logic hit_floor = wr & (i_avm.address == LECR_OFS_EQ_FLOOR);
  wire logic hit_en = wr & (i_avm.address == LECR_OFS_IRQ_EN);
  wire logic hit_clr = wr & (i_avm.address == LECR_OFS_IRQ_CLR);

  // (R3) cable mode source select
  wire logic long_cable_mode = eq_ctrl[LECR_BIT_LONG_CABLE_MODE_OVR] ? eq_ctrl[LECR_BIT_LONG_CABLE_MODE] : strap_s2;
  // (R4) floor from register in long cable mode
  wire logic [3:0] floor_lvl = long_cable_mode ? eq_floor[3:0] : LECR_DEF_FLOOR;
  wire logic [5:0] floor6 = {2'b00, floor_lvl};
  wire logic bypass = eq_byp[LECR_BIT_BYPASS];
  // (R13) stage one, (R14) stage two form the static level
  wire logic [5:0] static_lvl = {eq_byp[7:5], eq_byp[3:1]};
  // (R11) any bad marker bit is an error
  wire logic link_err = frame_s2.frame_valid &
    (~frame_s2.embedded_clock_bit_a | frame_s2.embedded_clock_bit_b | ~frame_s2.data_control_marker_bit);
  wire logic cnt_en = err_cnt[LECR_BIT_CNT_EN];
  wire logic [3:0] thr = err_cnt[3:0];
  wire logic [3:0] cnt_inc = err_count + 4'h1;
  // (R9) threshold, (R10) single error when disabled
  wire logic lose = link_err & (~cnt_en | (cnt_inc >= thr));
  wire logic step = (step_cnt == 8'(STEP_CYC - 1));
  wire logic settle_evt = (eq_state == LECR_EQ_SEARCH) & step & good_s2;
  wire logic [7:0] evt = {5'b0, settle_evt, link_err, lose & o_lock};

  always_comb begin
    case (i_avm.address)
      LECR_OFS_EQ_CTRL: rd_byte = eq_ctrl;
      LECR_OFS_PG_CLK: rd_byte = pg_clk;
      LECR_OFS_AUD_DIV: rd_byte = aud_div;
      LECR_OFS_EQ_STAT: rd_byte = {2'b00, o_eq_level};
      LECR_OFS_ERR_CNT: rd_byte = err_cnt;
      LECR_OFS_EQ_BYP: rd_byte = eq_byp;
      LECR_OFS_EQ_FLOOR: rd_byte = eq_floor;
      LECR_OFS_IRQ_STAT: rd_byte = irq_stat;
      LECR_OFS_IRQ_EN: rd_byte = irq_en;
      LECR_OFS_LINK_STAT: rd_byte = {3'b000, o_lock, err_count};
      default: rd_byte = 8'h00;
    endcase
  end

  // one wait cycle per access; unmapped reads return zero
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ack <= 1'b0;
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h0000_0000;
    end else begin
      ack <= acc;
      o_waitrequest <= ~acc;
      if (acc) begin
        o_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      eq_ctrl <= LECR_RST_EQ_CTRL;
      pg_clk <= LECR_RST_PG_CLK;
      aud_div <= LECR_RST_AUD_DIV;
      err_cnt <= LECR_RST_ERR_CNT;
      eq_byp <= LECR_RST_EQ_BYP;
      eq_floor <= LECR_RST_EQ_FLOOR;
      irq_en <= 8'h00;
    end else begin
      if (hit_ctrl) eq_ctrl <= wd_ctrl;
      if (hit_pg) pg_clk <= wd & LECR_MSK_PG_CLK;
      if (hit_aud) aud_div <= wd & LECR_MSK_AUD_DIV;
      if (hit_err) err_cnt <= wd & LECR_MSK_ERR_CNT;
      if (hit_byp) eq_byp <= wd & LECR_MSK_EQ_BYP;
      if (hit_floor) eq_floor <= wd & LECR_MSK_EQ_FLOOR;
      if (hit_en) irq_en <= wd & LECR_MSK_IRQ;
    end
  end

  // set wins over clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(hit_clr ? wd : 8'h00)) | (evt & LECR_MSK_IRQ);
      o_irq <= |(irq_stat & irq_en);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      frame_s1 <= '0;
      frame_s2 <= '0;
      good_s1 <= 1'b0;
      good_s2 <= 1'b0;
    end else begin
      strap_s1 <= i_mode_strap;
      strap_s2 <= strap_s1;
      frame_s1 <= i_frame;
      frame_s2 <= frame_s1;
      good_s1 <= i_eq_good;
      good_s2 <= good_s1;
    end
  end

  // (R8) counting only when enabled
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      err_count <= 4'h0;
      o_lock <= 1'b1;
    end else if (lose) begin
      err_count <= 4'h0;
      o_lock <= 1'b0;
    end else begin
      if (link_err & cnt_en) err_count <= cnt_inc;
      if (frame_s2.frame_valid & ~link_err) o_lock <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      step_cnt <= 8'h00;
    end else begin
      step_cnt <= step ? 8'h00 : step_cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      eq_state <= LECR_EQ_RESTART;
      eq_adapt <= LECR_EQ_INIT;
    end else if (eq_ctrl[LECR_BIT_RESTART]) begin
      // (R1) held at floor until software clears
      eq_state <= LECR_EQ_RESTART;
      eq_adapt <= floor6;
    end else begin
      case (eq_state)
        LECR_EQ_RESTART: begin
          eq_adapt <= floor6;
          eq_state <= LECR_EQ_SEARCH;
        end
        LECR_EQ_SEARCH: begin
          // (R12) search frozen while bypassed
          if (step & ~bypass) begin
            if (good_s2) eq_state <= LECR_EQ_HOLD;
            else if (eq_adapt == 6'h3f) eq_adapt <= floor6;
            else eq_adapt <= eq_adapt + 6'h01;
          end
        end
        LECR_EQ_HOLD: begin
          if (~o_lock & ~bypass) eq_state <= LECR_EQ_RESTART;
        end
        default: eq_state <= LECR_EQ_RESTART;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_eq_level <= LECR_EQ_INIT;
      o_pattern_internal_clock_select <= 1'b0;
      o_audio_div_override <= 1'b0;
      o_audio_div <= 3'b000;
      o_long_cable_mode <= 1'b0;
    end else begin
      // (R7) readout follows applied level
      o_eq_level <= bypass ? static_lvl : eq_adapt;
      // (R5) pattern clock choice
      o_pattern_internal_clock_select <= pg_clk[LECR_BIT_PG_INT];
      // (R6) divider override
      o_audio_div_override <= aud_div[LECR_BIT_DIV_OVR];
      o_audio_div <= aud_div[6:4];
      // (R15) floor active in either cable mode source
      o_long_cable_mode <= long_cable_mode;
    end
  end

  // the level reaches the output two edges after the floor is taken
  restart_floor_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R1)
    eq_ctrl[LECR_BIT_RESTART] && !bypass ##1 !bypass |=> o_eq_level == $past(floor6, 2))
    else $error("restart did not apply floor");
  restart_hold_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R1)
    eq_ctrl[LECR_BIT_RESTART] |=> eq_state == LECR_EQ_RESTART)
    else $error("search ran during restart");
  long_cable_mode_source_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R3)
    ##1 o_long_cable_mode == $past(eq_ctrl[5] ? eq_ctrl[4] : strap_s2))
    else $error("cable mode source wrong");
  floor_use_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R4)
    eq_ctrl[LECR_BIT_RESTART] && !bypass && long_cable_mode ##1 !bypass |=>
      o_eq_level == {2'b00, $past(eq_floor[3:0], 2)})
    else $error("floor not from register");
  pg_clock_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R5)
    ##1 o_pattern_internal_clock_select == $past(pg_clk[1]))
    else $error("pattern clock select wrong");
  audio_div_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R6)
    ##1 o_audio_div_override == $past(aud_div[7]) && o_audio_div == $past(aud_div[6:4]))
    else $error("audio divider wrong");
  level_readout_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R7)
    !bypass |=> o_eq_level == $past(eq_adapt))
    else $error("readout differs from adaptive level");
  bypass_level_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R12)
    bypass |=> o_eq_level == {$past(eq_byp[7:5]), $past(eq_byp[3:1])})
    else $error("bypass level not applied");
  single_err_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R10)
    link_err && !cnt_en |=> !o_lock)
    else $error("lock kept after error");
  thresh_drop_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R9)
    link_err && cnt_en && cnt_inc >= thr |=> !o_lock && err_count == 4'h0)
    else $error("threshold did not drop lock");
  count_off_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R8)
    !cnt_en |=> err_count == 4'h0 || $stable(err_count))
    else $error("counted while disabled");
  marker_ok_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R11)
    frame_s2.frame_valid && frame_s2.embedded_clock_bit_a && !frame_s2.embedded_clock_bit_b &&
      frame_s2.data_control_marker_bit |=> o_lock)
    else $error("good frame lost lock");
  marker_bad_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R11)
    frame_s2.frame_valid && !cnt_en &&
      (!frame_s2.embedded_clock_bit_a || frame_s2.embedded_clock_bit_b ||
      !frame_s2.data_control_marker_bit) |=> !o_lock)
    else $error("bad marker bit not caught");
  reserved_zero_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R16)
    (eq_ctrl & ~LECR_MSK_EQ_CTRL) == 8'h00 && (eq_byp & ~LECR_MSK_EQ_BYP) == 8'h00)
    else $error("reserved bits set");
  reserved_more_a: assert property (@(posedge i_clk) disable iff (i_reset) // (R16)
    (pg_clk & ~LECR_MSK_PG_CLK) == 8'h00 && (aud_div & ~LECR_MSK_AUD_DIV) == 8'h00 &&
      (err_cnt & ~LECR_MSK_ERR_CNT) == 8'h00)
    else $error("reserved bits set in clock, divider or count");
  // waitrequest drops for one cycle only, so no access is answered twice
  wait_pulse_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low twice");
  // a lock loss that meets a clear still leaves its status bit set
  lock_event_a: assert property (@(posedge i_clk) disable iff (i_reset)
    lose && o_lock |=> irq_stat[LECR_IRQ_LOCK_LOST])
    else $error("lock loss not recorded");
endmodule : lecr_regs

// ---- design/lecr_pkg.sv ----
// Contract
// (R1) restart bit holds adaptation at floor
// (R2) software clears restart bit itself
// (R3) bit5 picks strap or register cable mode
// (R4) long cable mode uses programmed floor
// (R5) bit1 selects pattern internal pixel clock
// (R6) bit7 overrides audio divider with bits 6:4
// (R7) status shows equalizer level applied
// (R8) bit4 enables link error counting
// (R9) drop lock when count reaches threshold
// (R10) counting disabled: first error drops lock
// (R11) check clock bits and marker bit
// (R12) bypass bit freezes equalizer at static stages
// (R13) stage one field used only when bypassed
// (R14) stage two field used only when bypassed
// (R15) floor field applies in long cable mode
// (R16) reserved bits ignore writes, read zero
package lecr_pkg;
  localparam logic [7:0] LECR_OFS_EQ_CTRL = 8'h35;
  localparam logic [7:0] LECR_OFS_PG_CLK = 8'h39;
  localparam logic [7:0] LECR_OFS_AUD_DIV = 8'h3a;
  localparam logic [7:0] LECR_OFS_EQ_STAT = 8'h3b;
  localparam logic [7:0] LECR_OFS_ERR_CNT = 8'h41;
  localparam logic [7:0] LECR_OFS_EQ_BYP = 8'h44;
  localparam logic [7:0] LECR_OFS_EQ_FLOOR = 8'h45;
  localparam logic [7:0] LECR_OFS_IRQ_STAT = 8'h50;
  localparam logic [7:0] LECR_OFS_IRQ_EN = 8'h51;
  localparam logic [7:0] LECR_OFS_IRQ_CLR = 8'h52;
  localparam logic [7:0] LECR_OFS_LINK_STAT = 8'h53;
  // writable bit masks; everything else is reserved
  localparam logic [7:0] LECR_MSK_EQ_CTRL = 8'h70;
  localparam logic [7:0] LECR_MSK_PG_CLK = 8'h02;
  localparam logic [7:0] LECR_MSK_AUD_DIV = 8'hf0;
  localparam logic [7:0] LECR_MSK_ERR_CNT = 8'h1f;
  localparam logic [7:0] LECR_MSK_EQ_BYP = 8'hef;
  localparam logic [7:0] LECR_MSK_EQ_FLOOR = 8'hff;
  localparam logic [7:0] LECR_MSK_IRQ = 8'h07;
  localparam logic [7:0] LECR_RST_EQ_CTRL = 8'h00;
  localparam logic [7:0] LECR_RST_PG_CLK = 8'h00;
  localparam logic [7:0] LECR_RST_AUD_DIV = 8'h00;
  localparam logic [7:0] LECR_RST_ERR_CNT = 8'h03;
  localparam logic [7:0] LECR_RST_EQ_BYP = 8'h60;
  localparam logic [7:0] LECR_RST_EQ_FLOOR = 8'h88;
  localparam int LECR_BIT_RESTART = 6;
  localparam int LECR_BIT_LONG_CABLE_MODE_OVR = 5;
  localparam int LECR_BIT_LONG_CABLE_MODE = 4;
  localparam int LECR_BIT_PG_INT = 1;
  localparam int LECR_BIT_DIV_OVR = 7;
  localparam int LECR_BIT_CNT_EN = 4;
  localparam int LECR_BIT_BYPASS = 0;
  localparam int LECR_IRQ_LOCK_LOST = 0;
  localparam int LECR_IRQ_LINK_ERR = 1;
  localparam int LECR_IRQ_EQ_SETTLED = 2;
  localparam logic [5:0] LECR_EQ_INIT = 6'h00;
  localparam logic [3:0] LECR_DEF_FLOOR = 4'h0;
  localparam int LECR_ADAPT_STEP_NS = 1000;
  localparam int LECR_CLK_NS = 100;
  localparam int LECR_ADAPT_STEP_CYC = LECR_ADAPT_STEP_NS / LECR_CLK_NS;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } lecr_avm_req_s;

  typedef struct packed {
    logic embedded_clock_bit_a;
    logic embedded_clock_bit_b;
    logic data_control_marker_bit;
    logic frame_valid;
  } lecr_frame_s;

  typedef enum logic [1:0] {
    LECR_EQ_RESTART,
    LECR_EQ_SEARCH,
    LECR_EQ_HOLD
  } lecr_eq_e;
endpackage : lecr_pkg

// ---- test/lecr_serializer_model.sv ----
module lecr_serializer_model (
  input wire logic i_clk, // pixel clock
  input wire logic i_send, // emit one frame this cycle
  input wire logic [1:0] i_fault, // 0 good, 1..3 spoil one marker bit
  output lecr_pkg::lecr_frame_s o_frame // received frame markers
);
  timeunit 1ns;
  timeprecision 1ns;
  import lecr_pkg::*;
  logic churn = 1'b0;
  always @(posedge i_clk) begin
    churn <= ~churn;
    if (i_send) begin
      o_frame <= '{i_fault != 2'h1, i_fault == 2'h2, i_fault != 2'h3, 1'b1};
    end else begin
      // between frames the lines churn, so stale bits never pass for a frame
      o_frame <= '{churn, ~churn, churn, 1'b0};
    end
  end
endmodule : lecr_serializer_model

// ---- test/link_equalizer_control_regs_test.sv ----
module link_equalizer_control_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import lecr_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] r;
    logic [7:0] d;
    logic [7:0] e;
  } lecr_row_s;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_mode_strap = 1'b0;
  logic i_eq_good = 1'b0;
  logic send = 1'b0;
  logic [1:0] fault = 2'h0;
  lecr_avm_req_s avm = '0;
  lecr_frame_s frame;
  logic [31:0] o_readdata;
  logic [5:0] o_eq_level;
  logic [2:0] o_audio_div;
  logic o_waitrequest, o_pattern_internal_clock_select, o_audio_div_override, o_lock, o_long_cable_mode, o_irq;
  logic [7:0] rd_seen = 8'h00;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  lecr_row_s rows [10] = '{
    '{8'h35, 8'h00, 8'hff, 8'h70}, '{8'h39, 8'h00, 8'hff, 8'h02}, '{8'h3a, 8'h00, 8'hff, 8'hf0},
    '{8'h41, 8'h03, 8'hff, 8'h1f}, '{8'h44, 8'h60, 8'hff, 8'hef}, '{8'h45, 8'h88, 8'h5a, 8'h5a},
    '{8'h52, 8'h00, 8'hff, 8'h00}, '{8'h60, 8'h00, 8'hff, 8'h00}, '{8'h50, 8'h00, 8'hff, 8'h00},
    '{8'h51, 8'h00, 8'hff, 8'h07}};

  lecr_regs u_lecr_regs (.i_clk(i_clk), .i_reset(i_reset), .i_avm(avm), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_mode_strap(i_mode_strap), .i_frame(frame), .i_eq_good(i_eq_good),
    .o_eq_level(o_eq_level), .o_pattern_internal_clock_select(o_pattern_internal_clock_select),
    .o_audio_div_override(o_audio_div_override), .o_audio_div(o_audio_div), .o_lock(o_lock),
    .o_long_cable_mode(o_long_cable_mode), .o_irq(o_irq));
  lecr_serializer_model u_lecr_serializer_model (.i_clk(i_clk), .i_send(send), .i_fault(fault), .o_frame(frame));

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    avm <= '{a, !wr, wr, {24'h00_0000, d}};
    // the wait ends once waitrequest is seen low; the bench timeout ends it if that never happens
    do begin
      @(posedge i_clk);
    end while (o_waitrequest !== 1'b0);
    rd_seen = o_readdata[7:0];
    avm <= '0;
  endtask : bus

  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd_seen, e);
  endtask : rd_chk

  task frm(input logic [1:0] f);
    @(posedge i_clk);
    send <= 1'b1;
    fault <= f;
    @(posedge i_clk);
    send <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask : frm

  initial begin
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) begin
      rd_chk(rows[i].a, rows[i].r);
      bus(1'b1, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    bus(1'b1, 8'h3a, 8'hd5);
    repeat (2) @(posedge i_clk);
    chk({7'h00, o_pattern_internal_clock_select}, 8'h01);
    chk({4'h0, o_audio_div_override, o_audio_div}, 8'h0d);
    bus(1'b1, 8'h3a, 8'h55);
    repeat (2) @(posedge i_clk);
    chk({7'h00, o_audio_div_override}, 8'h00);
    bus(1'b1, 8'h44, 8'ha7);
    repeat (3) @(posedge i_clk);
    chk({2'h0, o_eq_level}, 8'h2b);
    rd_chk(8'h3b, 8'h2b);
    bus(1'b1, 8'h44, 8'ha6);
    bus(1'b1, 8'h35, 8'h40);
    repeat (4) @(posedge i_clk);
    chk({2'h0, o_eq_level}, 8'h00);
    chk({7'h00, o_long_cable_mode}, 8'h00);
    i_mode_strap <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk({7'h00, o_long_cable_mode}, 8'h01);
    chk({2'h0, o_eq_level}, 8'h0a);
    bus(1'b1, 8'h35, 8'h60);
    repeat (4) @(posedge i_clk);
    chk({6'h00, o_long_cable_mode, o_eq_level == 6'h00}, 8'h01);
    bus(1'b1, 8'h35, 8'h70);
    repeat (4) @(posedge i_clk);
    chk({6'h00, o_long_cable_mode, o_eq_level == 6'h0a}, 8'h03);
    // restart completes only once software writes the bit back to zero
    bus(1'b1, 8'h35, 8'h30);
    repeat (25) @(posedge i_clk);
    chk({7'h00, o_eq_level > 6'h0a}, 8'h01);
    i_eq_good <= 1'b1;
    bus(1'b1, 8'h41, 8'h03);
    for (int k = 1; k < 4; k++) begin
      frm(k[1:0]);
      chk({7'h00, o_lock}, 8'h00);
      frm(2'h0);
      chk({7'h00, o_lock}, 8'h01);
    end
    bus(1'b1, 8'h41, 8'h13);
    frm(2'h1);
    frm(2'h2);
    chk({7'h00, o_lock}, 8'h01);
    frm(2'h3);
    chk({7'h00, o_lock}, 8'h00);
    frm(2'h0);
    bus(1'b1, 8'h51, 8'h00);
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_irq}, 8'h00);
    bus(1'b1, 8'h52, 8'h07);
    bus(1'b1, 8'h51, 8'h01);
    bus(1'b1, 8'h41, 8'h03);
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_irq}, 8'h00);
    frm(2'h1);
    chk({7'h00, o_irq}, 8'h01);
    rd_chk(8'h53, 8'h00);
    repeat (12) @(posedge i_clk);
    rd_chk(8'h50, 8'h07);
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({6'h00, o_lock, o_irq}, 8'h02);
    i_reset <= 1'b0;
    rd_chk(8'h44, 8'h60);
    close_out();
  end
endmodule : link_equalizer_control_regs_test
